// *** src/scg_regs.svh ***
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH

// register byte offsets
`define SCG_ADDR_PIN_CTL_ONE   8'h00
`define SCG_ADDR_PIN_CTL_TWO   8'h04
`define SCG_ADDR_PIN_STATUS    8'h08
`define SCG_ADDR_CENTRAL       8'h0c
`define SCG_ADDR_STRAP_CFG     8'h10

// field positions
`define SCG_GLOBAL_RESET_BIT   15
`define SCG_IO1_SEL_TOP_BIT    8
`define SCG_LOW_EDGE_LSB       12
`define SCG_HIGH_EDGE_LSB      14
`define SCG_STATUS_LATCH_LSB   8
`define SCG_FREQ_BIT           0
`define SCG_SQUELCH_BIT        1

// reset values and forced strap values
`define SCG_CTL_ONE_RESET      15'h0000
`define SCG_CTL_TWO_RESET      16'h0000
`define SCG_CENTRAL_RESET      2'h0
`define SCG_REDUCED_REF_FREQ   2'h2
`define SCG_REDUCED_SPEED      2'h2
`define SCG_REDUCED_ADDR       5'h04
`define SCG_FACTORY_ADDR       5'h1f
`define SCG_DIFF_CLK_DEFAULT   1'h1
`define SCG_TENBIT_RATE_DEFAULT 1'h1
`define SCG_AUTONEG_DEFAULT    1'h1

// timing: length of the internal reset started by the global reset bit
`define SCG_SOFT_RESET_CYCLES  4'h8

`endif

// *** src/scg_pkg.sv ***
package scg_pkg;

    // pin function select codes
    typedef enum logic [2:0] {
        SEL_HIZ    = 3'b000,
        SEL_LOW    = 3'b001,
        SEL_HIGH   = 3'b010,
        SEL_IRQ    = 3'b011,
        SEL_TXPLL  = 3'b100,
        SEL_RECCLK = 3'b101,
        SEL_STATUS = 3'b110,
        SEL_RSVD   = 3'b111
    } scg_sel_t;

    // latched status transition select
    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_BOTH = 2'b10,
        EDGE_NONE = 2'b11
    } scg_edge_t;

    // raw strap pin levels
    typedef struct packed {
        logic       collision;
        logic       carrier_sense;
        logic       gen_out_one;
        logic       gen_out_two;
        logic [7:0] rx_data;
        logic       rx_error;
        logic       rx_valid;
        logic       tx_clock;
    } scg_strap_t;

    // configuration fields set from the straps
    typedef struct packed {
        logic       factory_test;
        logic       reduced_mode;
        logic       diff_clk_enable;
        logic       tx_clock_out_enable;
        logic       autoneg_enable;
        logic       tenbit_rate_select;
        logic [4:0] mgmt_address;
        logic [1:0] ref_freq_select;
        logic       terminal_role_select;
        logic       serial_mode_select;
        logic       double_rate;
        logic [1:0] speed_field;
    } scg_cfg_t;

    // latched squelch sources
    typedef struct packed {
        logic analog_signal_loss;
        logic recovery_signal_loss;
        logic recovery_lock_loss;
        logic link_state_latched;
    } scg_loss_t;

endpackage

// *** src/scg_top.sv ***
`include "scg_regs.svh"

module scg_top (
    // apb slave
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // strap-only pin levels
    input  wire logic                collision_pin,
    input  wire logic                carrier_sense_pin,
    input  wire logic [7:0]          rx_data_pin,
    input  wire logic                receive_error_pin,
    input  wire logic                receive_valid_pin,
    // transmit clock pin
    input  wire logic                transmit_clock_pin_in,
    output logic                     transmit_clock_pin_out,
    output logic                     transmit_clock_pin_oe,
    // general output pins
    input  wire logic                gen_out_one_in,
    output logic                     gen_out_one,
    output logic                     gen_out_one_oe,
    input  wire logic                gen_out_two_in,
    output logic                     gen_out_two,
    output logic                     gen_out_two_oe,
    // bidirectional pins, bit 0 is gen_io_one
    input  wire logic [6:0]          gen_io_in,
    output logic [6:0]               gen_io_out,
    output logic [6:0]               gen_io_oe,
    // internal sources
    input  wire logic                tx_pll_clk,
    input  wire logic                rec_clk_25,
    input  wire logic                rec_clk_125,
    input  wire logic                link_up,
    input  wire logic                carrier_sense,
    input  wire logic                irq_n,
    input  wire scg_pkg::scg_loss_t  loss_status,
    // configuration result
    output scg_pkg::scg_cfg_t        cfg
);

    ////////////////////////////////////////////////////////////////////////////
    // reset control

    logic [3:0]           soft_cnt;
    logic                 strapping;
    logic                 soft_busy;
    logic                 rst_int_n;
    logic                 pads_hiz;
    logic [14:0]          ctl_one;
    logic [15:0]          ctl_two;
    logic [1:0]           central;
    logic [6:0]           latched;
    wire                  wr_en;
    wire                  wr_ctl_one;
    wire                  wr_status;

    assign soft_busy = (soft_cnt != 4'h0);
    assign rst_int_n = presetn & ~soft_busy;
    assign pads_hiz  = ~rst_int_n | strapping;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_cnt <= 4'h0;
        end else if (wr_ctl_one && pwdata[`SCG_GLOBAL_RESET_BIT]) begin
            soft_cnt <= `SCG_SOFT_RESET_CYCLES;
        end else if (soft_busy) begin
            soft_cnt <= soft_cnt - 4'h1;
        end
    end

    // sample window: one edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strapping <= 1'b1;
        end else begin
            strapping <= soft_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap capture

    scg_pkg::scg_strap_t  strap_s1;
    scg_pkg::scg_strap_t  strap_s2;
    scg_pkg::scg_cfg_t    cfg_new;
    wire                  is_mii;
    wire                  is_tenbit;

    // pin synchroniser, no reset so it tracks pins during reset
    always_ff @(posedge pclk) begin
        strap_s1 <= {collision_pin, carrier_sense_pin, gen_out_one_in, gen_out_two_in,
                     rx_data_pin, receive_error_pin, receive_valid_pin,
                     transmit_clock_pin_in};
        strap_s2 <= strap_s1;
    end

    assign is_mii    = ~strap_s2.carrier_sense & ~strap_s2.rx_data[1];
    assign is_tenbit = strap_s2.rx_data[1] & strap_s2.rx_data[0];

    assign cfg_new.reduced_mode = strap_s2.collision;
    assign cfg_new.double_rate  = strap_s2.carrier_sense;
    assign cfg_new.speed_field  = strap_s2.collision ? `SCG_REDUCED_SPEED
                                                     : strap_s2.rx_data[1:0];
    assign cfg_new.serial_mode_select   = ~strap_s2.collision & is_mii ? 1'b0
                                                                      : strap_s2.gen_out_two;
    assign cfg_new.terminal_role_select = ~strap_s2.collision & is_mii & strap_s2.gen_out_two;
    assign cfg_new.ref_freq_select = strap_s2.collision ? `SCG_REDUCED_REF_FREQ
                                                        : strap_s2.rx_data[3:2];
    assign cfg_new.mgmt_address = strap_s2.collision ? `SCG_REDUCED_ADDR
                                  : {strap_s2.rx_error, strap_s2.rx_data[7:4]};
    assign cfg_new.factory_test = (cfg_new.mgmt_address == `SCG_FACTORY_ADDR);
    assign cfg_new.tenbit_rate_select = ~strap_s2.collision & is_tenbit ? strap_s2.rx_valid
                                        : `SCG_TENBIT_RATE_DEFAULT;
    assign cfg_new.autoneg_enable = strap_s2.collision ? 1'b1
                                    : is_tenbit ? `SCG_AUTONEG_DEFAULT
                                    : strap_s2.rx_valid;
    assign cfg_new.tx_clock_out_enable = strap_s2.collision | strap_s2.tx_clock;
    assign cfg_new.diff_clk_enable     = strap_s2.collision ? 1'b0 : `SCG_DIFF_CLK_DEFAULT;

    always_ff @(posedge pclk) begin
        if (strapping) begin
            cfg <= cfg_new;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave

    wire                  setup_ph;
    wire                  hit_one;
    wire                  hit_two;
    wire                  hit_stat;
    wire                  hit_cent;
    wire                  hit_cfg;
    wire                  hit_any;
    wire [31:0]           rd_mux;
    wire [6:0]            live;

    assign setup_ph   = psel & ~penable;
    assign wr_en      = psel & penable & pwrite;
    assign hit_one    = (paddr == `SCG_ADDR_PIN_CTL_ONE);
    assign hit_two    = (paddr == `SCG_ADDR_PIN_CTL_TWO);
    assign hit_stat   = (paddr == `SCG_ADDR_PIN_STATUS);
    assign hit_cent   = (paddr == `SCG_ADDR_CENTRAL);
    assign hit_cfg    = (paddr == `SCG_ADDR_STRAP_CFG);
    assign hit_any    = hit_one | hit_two | hit_stat | hit_cent | hit_cfg;
    assign wr_ctl_one = wr_en & hit_one;
    assign wr_status  = wr_en & hit_stat;
    assign pready     = 1'b1;

    // read mux, global reset bit reads zero
    assign rd_mux = hit_one  ? {17'h00000, ctl_one} :
                    hit_two  ? {16'h0000, ctl_two} :
                    hit_stat ? {17'h00000, latched, 1'b0, live} :
                    hit_cent ? {30'h00000000, central} :
                    hit_cfg  ? {14'h0000, cfg} : 32'h00000000;

    // read data and error captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= ~hit_any;
        end
    end

    always_ff @(posedge pclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            ctl_one <= `SCG_CTL_ONE_RESET;
            ctl_two <= `SCG_CTL_TWO_RESET;
            central <= `SCG_CENTRAL_RESET;
        end else if (strapping) begin
            ctl_one <= `SCG_CTL_ONE_RESET;
            ctl_one[`SCG_IO1_SEL_TOP_BIT] <= ~strap_s2.collision & strap_s2.gen_out_one;
            ctl_two <= `SCG_CTL_TWO_RESET;
        end else begin
            if (wr_ctl_one) begin
                ctl_one <= pwdata[14:0];
            end
            if (wr_en && hit_two) begin
                ctl_two <= pwdata[15:0];
            end
            if (wr_en && hit_cent) begin
                central <= pwdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // io input side

    logic [6:0]           io_s1;
    logic [6:0]           io_s2;
    logic [6:0]           io_s3;
    wire                  high_avail;
    scg_pkg::scg_edge_t   low_edge;
    scg_pkg::scg_edge_t   high_edge;

    // upper pins only in MII, RGMII, RTBI
    assign high_avail = cfg.double_rate | ~cfg.speed_field[1];
    assign low_edge   = scg_pkg::scg_edge_t'(ctl_two[`SCG_LOW_EDGE_LSB +: 2]);
    assign high_edge  = scg_pkg::scg_edge_t'(ctl_two[`SCG_HIGH_EDGE_LSB +: 2]);
    assign live       = io_s2;

    // io synchroniser, reset to idle high
    always_ff @(posedge pclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            io_s1 <= 7'h7f;
            io_s2 <= 7'h7f;
            io_s3 <= 7'h7f;
        end else begin
            io_s1 <= gen_io_in;
            io_s2 <= io_s1;
            io_s3 <= io_s2;
        end
    end

    for (genvar i = 0; i < 7; i++) begin : g_latch
        scg_pkg::scg_edge_t es;
        wire                hit;
        assign es  = (i < 3) ? low_edge : high_edge;
        assign hit = ~strapping & ((i < 3) | high_avail) & (
                     (io_s2[i] & ~io_s3[i] & (es == scg_pkg::EDGE_RISE || es == scg_pkg::EDGE_BOTH))
                   | (~io_s2[i] & io_s3[i] & (es == scg_pkg::EDGE_FALL || es == scg_pkg::EDGE_BOTH)));
        always_ff @(posedge pclk or negedge rst_int_n) begin
            if (!rst_int_n) begin
                latched[i] <= 1'b0;
            end else if (hit) begin
                latched[i] <= 1'b1;
            end else if (wr_status && pwdata[`SCG_STATUS_LATCH_LSB + i]) begin
                latched[i] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin output functions

    wire [26:0]           sel_all;
    wire [8:0]            drv_val;
    wire [8:0]            drv_en;
    wire                  rec_clk;
    wire                  squelch;

    assign sel_all = {ctl_two[11:0], ctl_one};
    assign rec_clk = central[`SCG_FREQ_BIT] ? rec_clk_125 : rec_clk_25;
    assign squelch = central[`SCG_SQUELCH_BIT] &
                     (loss_status.analog_signal_loss | loss_status.recovery_signal_loss |
                      loss_status.recovery_lock_loss | ~loss_status.link_state_latched);

    // index 0 out-one, 1 out-two, 2..8 io one to seven
    for (genvar p = 0; p < 9; p++) begin : g_pin
        scg_pkg::scg_sel_t s;
        wire               grp_a;
        wire               grp_b;
        wire               open_drain;
        wire               usable;
        wire               val;
        wire               en;
        assign s          = scg_pkg::scg_sel_t'(sel_all[3*p +: 3]);
        assign grp_a      = (p == 0) || (p == 2) || (p == 4);
        assign grp_b      = (p == 1) || (p == 3);
        assign open_drain = (p == 2) || (p == 4);
        assign usable     = (p < 5) | high_avail;
        assign val = (s == scg_pkg::SEL_HIGH)   ? 1'b1 :
                     (s == scg_pkg::SEL_IRQ)    ? (open_drain ? 1'b0 : irq_n) :
                     (s == scg_pkg::SEL_TXPLL)  ? tx_pll_clk :
                     (s == scg_pkg::SEL_RECCLK) ? (grp_a ? rec_clk : rec_clk & ~squelch) :
                     (s == scg_pkg::SEL_STATUS) ? (grp_a ? link_up : carrier_sense) : 1'b0;
        // reserved codes leave the pin undriven
        assign en  = (s == scg_pkg::SEL_LOW) | (s == scg_pkg::SEL_HIGH) |
                     (s == scg_pkg::SEL_TXPLL) | (s == scg_pkg::SEL_RECCLK) |
                     ((s == scg_pkg::SEL_IRQ) & grp_a & (open_drain ? ~irq_n : 1'b1)) |
                     ((s == scg_pkg::SEL_STATUS) & (grp_a | grp_b));
        // undriven in reset or when unavailable
        assign drv_en[p]  = en & usable & ~pads_hiz;
        assign drv_val[p] = val & drv_en[p];
    end

    assign gen_out_one    = drv_val[0];
    assign gen_out_one_oe = drv_en[0];
    assign gen_out_two    = drv_val[1];
    assign gen_out_two_oe = drv_en[1];
    assign gen_io_out     = drv_val[8:2];
    assign gen_io_oe      = drv_en[8:2];

    // transmit clock output, ignored in MII and dual-clock ten-bit
    assign transmit_clock_pin_oe  = cfg.tx_clock_out_enable & ~pads_hiz &
                                    ~(~cfg.double_rate & ~cfg.speed_field[1]) &
                                    ~((cfg.speed_field == 2'h3) & cfg.tenbit_rate_select);
    assign transmit_clock_pin_out = tx_pll_clk & transmit_clock_pin_oe;

endmodule

// *** verification/scg_assertions.sv ***
module scg_assertions (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb request
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic               pready,
    // pads
    input  wire logic               gen_out_one,
    input  wire logic               gen_out_one_oe,
    input  wire logic               gen_out_two,
    input  wire logic               gen_out_two_oe,
    input  wire logic [6:0]         gen_io_out,
    input  wire logic [6:0]         gen_io_oe,
    input  wire logic               transmit_clock_pin_out,
    input  wire logic               transmit_clock_pin_oe,
    // sources and strap result
    input  wire logic               tx_pll_clk,
    input  wire logic               carrier_sense,
    input  wire logic               irq_n,
    input  wire scg_pkg::scg_loss_t loss_status,
    input  wire scg_pkg::scg_cfg_t  cfg
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] c1;
    logic [1:0]  cen;
    logic        k1;
    wire         wr = psel && penable && pwrite && pready;
    // software write shadow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1 <= 16'h0000;
            cen <= 2'h0;
            k1 <= 1'b0;
        end else if (wr && paddr == 8'h00) begin
            c1 <= pwdata[15:0];
            k1 <= !pwdata[15];
            if (pwdata[15]) cen <= 2'h0;
        end else if (wr && paddr == 8'h0c) begin
            cen <= pwdata[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_hiz;
        !gen_out_one_oe && !gen_out_two_oe && gen_io_oe == 7'h00;
    endsequence
    sequence s_soft;
        wr && paddr == 8'h00 && pwdata[15];
    endsequence
    property p_strap_hiz;
        $rose(presetn) |-> s_hiz;
    endproperty
    property p_soft;
        s_soft |=> s_hiz [*8];
    endproperty
    property p_reduced;
        cfg.reduced_mode |-> cfg.mgmt_address == 5'h04 && cfg.ref_freq_select == 2'h2
            && cfg.speed_field == 2'h2 && cfg.autoneg_enable && cfg.tx_clock_out_enable
            && !cfg.diff_clk_enable;
    endproperty
    property p_factory;
        !cfg.reduced_mode |-> cfg.factory_test == (cfg.mgmt_address == 5'h1f);
    endproperty
    property p_high_group;
        gen_io_oe[6:3] != 4'h0 |-> cfg.double_rate || !cfg.speed_field[1];
    endproperty
    property p_transmit_clock_pin;
        transmit_clock_pin_oe |-> cfg.tx_clock_out_enable && transmit_clock_pin_out == tx_pll_clk
            && (cfg.double_rate || cfg.speed_field[1])
            && !(cfg.speed_field == 2'h3 && cfg.tenbit_rate_select);
    endproperty
    property p_low_level;
        k1 && c1[5:3] == scg_pkg::SEL_LOW |-> gen_out_two_oe && !gen_out_two;
    endproperty
    property p_irq_push;
        k1 && c1[2:0] == scg_pkg::SEL_IRQ |-> gen_out_one_oe && gen_out_one == irq_n;
    endproperty
    property p_irq_drain;
        k1 && c1[8:6] == scg_pkg::SEL_IRQ |-> gen_io_oe[0] == !irq_n && !gen_io_out[0];
    endproperty
    property p_squelch;
        k1 && c1[5:3] == scg_pkg::SEL_RECCLK && cen[1]
            && (|loss_status[3:1] || !loss_status[0]) |-> !gen_out_two;
    endproperty
    property p_carrier;
        k1 && c1[5:3] == scg_pkg::SEL_STATUS |-> gen_out_two_oe && gen_out_two == carrier_sense;
    endproperty
    a_strap_hiz: assert property (p_strap_hiz)
        else $error("pads driven at strap");
    a_soft: assert property (p_soft)
        else $error("soft reset pads");
    a_reduced: assert property (p_reduced)
        else $error("three-pin fields");
    a_factory: assert property (p_factory)
        else $error("factory flag");
    a_high_group: assert property (p_high_group)
        else $error("io four-seven driven");
    a_transmit_clock_pin: assert property (p_transmit_clock_pin)
        else $error("tx clock pin");
    a_low_level: assert property (p_low_level)
        else $error("out two not low");
    a_irq_push: assert property (p_irq_push)
        else $error("out one irq");
    a_irq_drain: assert property (p_irq_drain)
        else $error("io one irq");
    a_squelch: assert property (p_squelch)
        else $error("no squelch");
    a_carrier: assert property (p_carrier)
        else $error("out two not carrier");
endmodule

bind scg_top scg_assertions scg_assertions_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .gen_out_one(gen_out_one),
    .gen_out_one_oe(gen_out_one_oe), .gen_out_two(gen_out_two), .gen_out_two_oe(gen_out_two_oe),
    .gen_io_out(gen_io_out), .gen_io_oe(gen_io_oe), .transmit_clock_pin_out(transmit_clock_pin_out),
    .transmit_clock_pin_oe(transmit_clock_pin_oe), .tx_pll_clk(tx_pll_clk),
    .carrier_sense(carrier_sense), .irq_n(irq_n), .loss_status(loss_status), .cfg(cfg)
);

// *** verification/scg_pins.sv ***
module scg_pins (
    // board straps and far-side drive
    input  wire scg_pkg::scg_strap_t strap,
    input  wire logic [6:0]          ext_en,
    input  wire logic [6:0]          ext_val,
    // device pads
    input  wire logic                out_one,
    input  wire logic                out_one_oe,
    input  wire logic                out_two,
    input  wire logic                out_two_oe,
    input  wire logic                txc,
    input  wire logic                txc_oe,
    input  wire logic [6:0]          io_out,
    input  wire logic [6:0]          io_oe,
    // levels seen by the device
    output scg_pkg::scg_strap_t      lvl,
    output logic [6:0]               io_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // straps; a driven pad wins over its resistor
    assign lvl = {strap.collision, strap.carrier_sense, out_one_oe ? out_one : strap.gen_out_one,
                  out_two_oe ? out_two : strap.gen_out_two, strap.rx_data, strap.rx_error,
                  strap.rx_valid, txc_oe ? txc : strap.tx_clock};
    assign io_in = (io_oe & io_out) | (~io_oe & ext_en & ext_val) | (~io_oe & ~ext_en);
endmodule

// *** verification/scg_top_tb.sv ***
module scg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  m1 = 8'h7e, v1 = 8'h74, m2 = 8'h76, v2 = 8'h74, m4 = 8'h36, v4 = 8'h34;
    localparam logic [13:0] e_full = {2'h2, 1'b1, 1'b1, 2'h1, 5'h05, 1'b1, 2'b00};
    localparam logic [13:0] e_red = {2'h2, 1'b1, 1'b0, 2'h2, 5'h04, 1'b1, 2'b01};
    // apb side
    logic        pclk;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, perr;
    // pads, far side and sources
    logic        txc, txc_oe, o1, o1_oe, o2, o2_oe;
    logic [6:0]  io_in, io_out, io_oe, ext_en = 7'h00, ext_val = 7'h00;
    logic        tpll = 1'b1, r25 = 1'b1, r125 = 1'b0, lnk = 1'b1, cs = 1'b1, irqn = 1'b0;
    scg_pkg::scg_loss_t  loss = 4'h1;
    scg_pkg::scg_cfg_t   cfg;
    scg_pkg::scg_strap_t st = 15'h0, lv;
    int          n_fail = 0, checks = 0;
    scg_top scg_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .collision_pin(lv.collision), .carrier_sense_pin(lv.carrier_sense),
        .rx_data_pin(lv.rx_data), .receive_error_pin(lv.rx_error), .receive_valid_pin(lv.rx_valid),
        .transmit_clock_pin_in(lv.tx_clock), .transmit_clock_pin_out(txc),
        .transmit_clock_pin_oe(txc_oe), .gen_out_one_in(lv.gen_out_one), .gen_out_one(o1),
        .gen_out_one_oe(o1_oe), .gen_out_two_in(lv.gen_out_two), .gen_out_two(o2),
        .gen_out_two_oe(o2_oe), .gen_io_in(io_in), .gen_io_out(io_out), .gen_io_oe(io_oe),
        .tx_pll_clk(tpll), .rec_clk_25(r25), .rec_clk_125(r125), .link_up(lnk),
        .carrier_sense(cs), .irq_n(irqn), .loss_status(loss), .cfg(cfg)
    );
    scg_pins scg_pins_inst (
        .strap(st), .ext_en(ext_en), .ext_val(ext_val), .out_one(o1), .out_one_oe(o1_oe),
        .out_two(o2), .out_two_oe(o2_oe), .txc(txc), .txc_oe(txc_oe), .io_out(io_out),
        .io_oe(io_oe), .lvl(lv), .io_in(io_in)
    );
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    function automatic logic [31:0] cf();
        return {cfg.speed_field, cfg.double_rate, cfg.serial_mode_select, cfg.ref_freq_select,
                cfg.mgmt_address, cfg.autoneg_enable, cfg.factory_test, cfg.reduced_mode};
    endfunction
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rst(input scg_pkg::scg_strap_t s);
        @(posedge pclk);
        st <= s;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        chk({o1_oe, o2_oe, txc_oe, io_oe}, 32'h0, "reset pads");
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic t_full;
        rst('{1'b0, 1'b1, 1'b1, 1'b1, 8'h56, 1'b0, 1'b1, 1'b1});
        chk(cf(), e_full, "strap");
        chk({io_oe[0], io_out[0], txc_oe}, 3'b111, "clock pads");
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h100, "io one sel");
        $display("test full done");
    endtask
    task automatic t_sel;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 8'h00, 32'(c * 73));
            apb(1'b1, 8'h04, 32'(c));
            @(negedge pclk);
            chk({o1_oe, o1, o2_oe, o2, io_oe[0], io_out[0], io_oe[3], io_out[3]},
                {m1[c], v1[c], m2[c], v2[c], m1[c], v1[c], m4[c], v4[c]}, "sel");
        end
        $display("test sel done");
    endtask
    task automatic t_squelch;
        apb(1'b1, 8'h00, 32'h16b);
        apb(1'b1, 8'h0c, 32'h2);
        for (int b = 0; b < 5; b++) begin
            @(posedge pclk);
            loss <= (b == 4) ? 4'h1 : 4'h1 ^ (4'h1 << b);
            irqn <= (b == 4);
            @(negedge pclk);
            chk({o2, io_out[0], o1}, {b == 4, 1'b1, b == 4}, "squelch");
        end
        apb(1'b1, 8'h0c, 32'h1);
        @(negedge pclk);
        chk({o2, io_out[0]}, 2'b00, "fast clock");
        $display("test squelch done");
    endtask
    task automatic t_status;
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h4000);
        @(posedge pclk);
        ext_en <= 7'h7f;
        ext_val <= 7'h08;
        repeat (4) @(posedge pclk);
        apb(1'b1, 8'h08, 32'h7f00);
        @(posedge pclk);
        ext_val <= 7'h02;
        repeat (4) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0a02, "edge latch");
        apb(1'b1, 8'h08, 32'h0200);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0802, "clear one");
        apb(1'b0, 8'h20, 32'h0);
        chk({perr, rd[30:0]}, 32'h8000_0000, "unmapped");
        ext_en <= 7'h00;
        $display("test status done");
    endtask
    task automatic t_soft;
        @(posedge pclk);
        st <= '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0};
        repeat (4) @(posedge pclk);
        chk(cf(), e_full, "held");
        apb(1'b1, 8'h00, 32'h8000);
        repeat (12) @(posedge pclk);
        chk(cf(), e_red, "resampled");
        chk(txc_oe, 1'b1, "reduced clock");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0, "ctl two zero");
        $display("test soft done");
    endtask
    task automatic t_table;
        for (int i = 0; i < 4; i++) begin
            rst('{1'b0, 1'b0, 1'b0, 1'b1, {4'h3, i[1:0], i[1:0]}, 1'b0, 1'b0, 1'b1});
            chk(cf(), {i[1:0], 1'b0, i > 1, i[1:0], 5'h03, i == 3, 2'b00}, "table");
            chk(txc_oe, i > 1, "tx clock");
            if (i < 2) chk(cfg.terminal_role_select, 1'b1, "role");
            if (i == 3) chk(cfg.tenbit_rate_select, 1'b0, "rate");
        end
        rst('{1'b0, 1'b0, 1'b0, 1'b0, 8'hf2, 1'b1, 1'b0, 1'b0});
        chk(cfg.factory_test, 1'b1, "factory");
        $display("test table done");
    endtask
    task automatic print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        t_full;
        t_sel;
        t_squelch;
        t_status;
        t_soft;
        t_table;
        print_verdict;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        print_verdict;
    end
endmodule
